// ==== sim/dlfs_framer_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlfs_chk
  import dlfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic net_ready,
  input wire logic ser_valid,
  input wire logic frame_active,
  input wire logic frame_done,
  input wire logic [DLFS_CNT_W-1:0] octet_num,
  input wire logic [7:0] octet_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_octet;
    ser_valid [*8];
  endsequence
  property p_first;
    start && !frame_active |-> ##[1:4] ser_valid;
  endproperty
  property p_octet;
    $rose(ser_valid) |-> s_octet;
  endproperty
  property p_ready;
    net_ready |=> !net_ready [*7];
  endproperty
  property p_num;
    frame_active && $changed(octet_num) |->
      octet_num == $past(octet_num) + 16'h1 || octet_num == 16'h0;
  endproperty
  property p_stand;
    $changed(octet_out) |=> $stable(octet_out) [*7];
  endproperty
  property p_done;
    frame_done |=> !frame_done;
  endproperty
  property p_done_idle;
    frame_done |-> !ser_valid;
  endproperty
  property p_valid;
    ser_valid |-> frame_active;
  endproperty
  a_first: assert property (p_first)
    else $error("first bit late");
  a_octet: assert property (p_octet)
    else $error("octet cut short");
  a_ready: assert property (p_ready)
    else $error("octets taken too fast");
  a_num: assert property (p_num)
    else $error("octet number skipped");
  a_stand: assert property (p_stand)
    else $error("octet value unstable");
  a_done: assert property (p_done)
    else $error("done pulse too long");
  a_done_idle: assert property (p_done_idle)
    else $error("bits after done");
  a_valid: assert property (p_valid)
    else $error("bits outside frame");
endmodule
bind dlfs_framer dlfs_chk u_chk (.ref_clk, .rst, .start, .net_ready,
  .ser_valid, .frame_active, .frame_done, .octet_num, .octet_out);
`default_nettype wire

// ==== sim/dlfs_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlfs_src_model
  import dlfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic txh_ready,
  input wire logic net_ready,
  output logic txh_valid,
  output dlfs_octet_t txh_in,
  output logic net_valid,
  output dlfs_octet_t net_in
);
  logic [7:0] ti;
  logic [7:0] ni;
  logic [7:0] nd;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ti <= 8'h0;
      ni <= 8'h0;
    end else begin
      if (txh_valid && txh_ready)
        ti <= txh_in.last ? 8'h0 : ti + 8'h1;
      if (net_valid && net_ready)
        ni <= net_in.last ? 8'h0 : ni + 8'h1;
    end
  end
  // The source owns the transmission header and the network data.
  assign txh_valid = 1'b1;
  assign txh_in = '{data: 8'hA5 ^ ti, last: ti == 8'h1};
  assign nd = {ni[3:0], ~ni[3:0]};
  // A stalled source shows inverted data so a stale octet cannot pass.
  assign net_valid = !stall;
  assign net_in = '{data: stall ? ~nd : nd, last: ni == 8'h4};
endmodule
`default_nettype wire

// ==== sim/tb_dlfs_framer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_dlfs_framer;
  import dlfs_pkg::*;
  logic ref_clk = 0, rst = 1, start = 0, inh_en = 0;
  logic txh_present = 0, stall = 0;
  dlfs_hdr_t hdr = '0;
  dlfs_inh_t inh = '0;
  logic txh_valid, txh_ready, net_valid, net_ready, ser_bit, ser_valid;
  logic frame_active, frame_done;
  dlfs_octet_t txh_in, net_in;
  logic [DLFS_CNT_W-1:0] octet_num;
  logic [7:0] octet_out, cur;
  logic [7:0] got[$], exp_q[$];
  int nb = 0, fails = 0, n_tests = 0;
  always #50 ref_clk = ~ref_clk;
  dlfs_framer uut (.ref_clk, .rst, .start, .hdr, .inh, .inh_en,
    .txh_present, .txh_valid, .txh_in, .txh_ready, .net_valid, .net_in,
    .net_ready, .ser_bit, .ser_valid, .frame_active, .frame_done,
    .octet_num, .octet_out);
  dlfs_src_model src (.ref_clk, .rst, .stall, .txh_ready, .net_ready,
    .txh_valid, .txh_in, .net_valid, .net_in);
  always @(negedge ref_clk) begin
    if (ser_valid === 1'b1) begin
      cur[nb] = ser_bit;
      if (nb == 7)
        got.push_back(cur);
      nb = (nb + 1) % 8;
    end
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run_frame(logic tx, logic ie, logic st, logic [31:0] f);
    int i;
    logic [7:0] rb;
    got.delete();
    exp_q.delete();
    nb = 0;
    if (tx)
      exp_q = '{8'hA5, 8'hA4};
    exp_q = {exp_q, DLFS_FLAG, 8'h0E, 8'h09, 8'h13};
    if (ie)
      exp_q = {exp_q, 8'h40, 8'h03, 8'h00};
    for (i = 0; i < 5; i++)
      exp_q.push_back({i[3:0], ~i[3:0]});
    for (i = 0; i < 4; i++) begin
      rb = {<<{f[31-8*i -: 8]}};
      exp_q.push_back(rb);
    end
    exp_q.push_back(DLFS_FLAG);
    @(posedge ref_clk);
    hdr <= '{cmd_resp: 1'b0, src_addr: 7'h07, ext_bit: 1'b1,
      dst_addr: 7'h04, control: 8'h13, fcs: f};
    inh <= '{version: 4'h0, msg_type: 4'h4, hdr_len: 8'h03, tos: 8'h00};
    txh_present <= tx;
    inh_en <= ie;
    start <= 1'b1;
    // A second start mid-frame must be ignored while not idle.
    for (i = 0; i < 3000 && frame_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      start <= (i == 0) || (st && i == 100);
      stall <= st && i > 40 && i < 90;
    end
    start <= 1'b0;
    if (i == 3000) begin
      fails++;
      report_and_stop();
    end
    repeat (20) @(negedge ref_clk);
    check("octet count", 16'(got.size()), 16'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < got.size(); i++)
      check("octet", {8'h0, got[i]}, {8'h0, exp_q[i]});
    check("last number", octet_num, 16'(exp_q.size() - 1));
    check("last octet", {8'h0, octet_out}, {8'h0, DLFS_FLAG});
  endtask
  task automatic t_full;
    run_frame(1'b1, 1'b1, 1'b0, 32'hCAE5E9EA);
  endtask
  task automatic t_stall_refuse;
    run_frame(1'b0, 1'b0, 1'b1, 32'h80000001);
  endtask
  task automatic t_reset_mid;
    @(posedge ref_clk) start <= 1'b1;
    @(posedge ref_clk) start <= 1'b0;
    repeat (30) @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    check("active in reset", {15'h0, frame_active}, 16'h0);
    check("valid in reset", {15'h0, ser_valid}, 16'h0);
    check("number in reset", octet_num, 16'h0);
    rst <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_full();
    t_stall_refuse();
    t_reset_mid();
    t_full();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== verilog/dlfs_bit_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlfs_bit_shifter
  import dlfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [DLFS_OCT_W-1:0] octet,
  output logic busy,
  output logic last_bit,
  output logic ser_bit
);

  logic [DLFS_OCT_W-1:0] shreg;
  logic [2:0] idx;
  logic active;
  logic [DLFS_OCT_W-1:0] next_shreg;
  logic [2:0] next_idx;
  logic next_active;

  always_comb begin
    next_shreg = shreg;
    next_idx = idx;
    next_active = active;
    if (load) begin
      next_shreg = octet;
      next_idx = DLFS_BIT_FIRST;
      next_active = 1'b1;
    end else if (active) begin
      // Bit 0 leaves first.
      next_shreg = {1'b0, shreg[DLFS_OCT_W-1:1]};
      next_idx = idx + 3'h1;
      if (idx == DLFS_BIT_LAST) begin
        next_active = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shreg <= '0;
      idx <= DLFS_BIT_FIRST;
      active <= 1'b0;
    end else begin
      shreg <= next_shreg;
      idx <= next_idx;
      active <= next_active;
    end
  end

  assign busy = active;
  assign last_bit = active && (idx == DLFS_BIT_LAST);
  assign ser_bit = shreg[0];

endmodule
`default_nettype wire

// ==== verilog/dlfs_framer.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlfs_framer
  import dlfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire dlfs_hdr_t hdr,
  input wire dlfs_inh_t inh,
  input wire logic inh_en,
  input wire logic txh_present,
  input wire logic txh_valid,
  input wire dlfs_octet_t txh_in,
  output logic txh_ready,
  input wire logic net_valid,
  input wire dlfs_octet_t net_in,
  output logic net_ready,
  output logic ser_bit,
  output logic ser_valid,
  output logic frame_active,
  output logic frame_done,
  output logic [DLFS_CNT_W-1:0] octet_num,
  output logic [7:0] octet_out
);

  dlfs_state_t state, next_state;
  dlfs_hdr_t hdr_q, next_hdr_q;
  dlfs_inh_t inh_q, next_inh_q;
  logic [2:0] fidx, next_fidx;
  logic [DLFS_CNT_W-1:0] cnt, next_cnt;
  logic [7:0] oct_q, next_oct_q;
  logic [DLFS_CNT_W-1:0] num_q, next_num_q;
  logic ser_valid_q, next_ser_valid_q;
  logic ser_bit_q, next_ser_bit_q;
  logic act_q, next_act_q;
  logic done_q, next_done_q;
  logic txr_q, next_txr_q;
  logic netr_q, next_netr_q;
  logic sh_load;
  logic sh_busy;
  logic sh_last;
  logic sh_bit;
  logic [7:0] cur_oct;
  logic cur_have;
  logic cur_last;
  logic [DLFS_FCS_W-1:0] fcs_rev;

  // The check value goes out MSB first, so its bit order is flipped and
  // then packed like any other field.
  for (genvar gi = 0; gi < DLFS_FCS_W; gi++) begin : g_fcs_rev
    assign fcs_rev[gi] = hdr_q.fcs[DLFS_FCS_W-1-gi];
  end

  // Octet source per state; fields pack LSB into the lowest free bit.
  always_comb begin
    cur_oct = '0;
    cur_have = 1'b0;
    cur_last = 1'b0;
    case (state)
      DLFS_TXH: begin
        cur_oct = txh_in.data;
        cur_have = txh_valid;
        cur_last = txh_in.last;
      end
      DLFS_FHDR: begin
        cur_have = 1'b1;
        cur_last = (cnt == DLFS_CNT_W'(DLFS_HDR_OCTETS - 1));
        case (cnt[1:0])
          2'h0: cur_oct = DLFS_FLAG;
          2'h1: cur_oct = {hdr_q.src_addr, hdr_q.cmd_resp};
          2'h2: cur_oct = {hdr_q.dst_addr, hdr_q.ext_bit};
          default: cur_oct = hdr_q.control;
        endcase
      end
      DLFS_INH: begin
        cur_have = 1'b1;
        cur_last = (cnt == DLFS_CNT_W'(DLFS_INH_OCTETS - 1));
        case (cnt[1:0])
          2'h0: cur_oct = {inh_q.msg_type, inh_q.version};
          2'h1: cur_oct = inh_q.hdr_len;
          default: cur_oct = inh_q.tos;
        endcase
      end
      DLFS_NET: begin
        cur_oct = net_in.data;
        cur_have = net_valid;
        cur_last = net_in.last;
      end
      DLFS_FCS: begin
        cur_have = 1'b1;
        cur_last = (cnt == DLFS_CNT_W'(DLFS_FCS_OCTETS - 1));
        cur_oct = fcs_rev[cnt[1:0]*DLFS_OCT_W +: DLFS_OCT_W];
      end
      DLFS_CLOSE: begin
        cur_have = 1'b1;
        cur_last = 1'b1;
        cur_oct = DLFS_FLAG;
      end
      default: begin
        cur_have = 1'b0;
      end
    endcase
  end

  // A new octet loads when the shifter is free or on its last bit, so bits
  // run back to back while the sources keep up.
  assign sh_load = (state != DLFS_IDLE) && cur_have && (!sh_busy || sh_last);

  always_comb begin
    next_state = state;
    next_hdr_q = hdr_q;
    next_inh_q = inh_q;
    next_fidx = fidx;
    next_cnt = cnt;
    next_oct_q = oct_q;
    next_num_q = num_q;
    next_done_q = 1'b0;
    next_act_q = act_q;
    next_ser_valid_q = sh_busy;
    next_ser_bit_q = sh_bit;
    next_txr_q = 1'b0;
    next_netr_q = 1'b0;
    if (state == DLFS_IDLE) begin
      // While the closing flag is still shifting the frame is not over, so
      // a start there is refused rather than swallowing the done pulse.
      if (start && !act_q) begin
        next_hdr_q = hdr;
        next_inh_q = inh;
        next_cnt = '0;
        next_fidx = 3'h0;
        next_act_q = 1'b1;
        next_state = txh_present ? DLFS_TXH : DLFS_FHDR;
      end else if (!sh_busy && act_q) begin
        next_act_q = 1'b0;
        next_done_q = 1'b1;
      end
    end else if (sh_load) begin
      next_oct_q = cur_oct;
      next_num_q = next_fidx == 3'h0 && state == DLFS_TXH && cnt == '0 ?
                   '0 : num_q + DLFS_CNT_W'(1);
      next_fidx = 3'h1;
      next_cnt = cnt + DLFS_CNT_W'(1);
      if (cur_last) begin
        next_cnt = '0;
        case (state)
          DLFS_TXH: next_state = DLFS_FHDR;
          DLFS_FHDR: next_state = inh_en ? DLFS_INH : DLFS_NET;
          DLFS_INH: next_state = DLFS_NET;
          DLFS_NET: next_state = DLFS_FCS;
          DLFS_FCS: next_state = DLFS_CLOSE;
          default: next_state = DLFS_IDLE;
        endcase
      end
    end
    if (fidx == 3'h0 && sh_load) begin
      next_num_q = '0;
    end
    next_txr_q = (next_state == DLFS_TXH);
    next_netr_q = (next_state == DLFS_NET);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= DLFS_IDLE;
      hdr_q <= '0;
      inh_q <= '0;
      fidx <= 3'h0;
      cnt <= '0;
      oct_q <= '0;
      num_q <= '0;
      done_q <= 1'b0;
      act_q <= 1'b0;
      ser_valid_q <= 1'b0;
      ser_bit_q <= 1'b0;
      txr_q <= 1'b0;
      netr_q <= 1'b0;
    end else begin
      state <= next_state;
      hdr_q <= next_hdr_q;
      inh_q <= next_inh_q;
      fidx <= next_fidx;
      cnt <= next_cnt;
      oct_q <= next_oct_q;
      num_q <= next_num_q;
      done_q <= next_done_q;
      act_q <= next_act_q;
      ser_valid_q <= next_ser_valid_q;
      ser_bit_q <= next_ser_bit_q;
      txr_q <= next_txr_q;
      netr_q <= next_netr_q;
    end
  end

  dlfs_bit_shifter u_shift (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(sh_load),
    .octet(cur_oct),
    .busy(sh_busy),
    .last_bit(sh_last),
    .ser_bit(sh_bit)
  );

  // Ready is a combinational pulse in the cycle an octet is consumed. This
  // trades a registered output for a handshake with no wait cycle.
  assign txh_ready = txr_q && sh_load && (state == DLFS_TXH);
  assign net_ready = netr_q && sh_load && (state == DLFS_NET);
  assign ser_bit = ser_bit_q;
  assign ser_valid = ser_valid_q;
  assign frame_active = act_q;
  assign frame_done = done_q;
  assign octet_num = num_q;
  assign octet_out = oct_q;

endmodule
`default_nettype wire

// ==== verilog/dlfs_pkg.sv ====
`default_nettype none
package dlfs_pkg;

  localparam logic [7:0] DLFS_FLAG = 8'h7E;
  localparam int DLFS_OCT_W = 8;
  localparam int DLFS_FCS_W = 32;
  localparam int DLFS_FCS_OCTETS = 4;
  localparam int DLFS_ADDR_W = 7;
  localparam int DLFS_NIB_W = 4;
  localparam int DLFS_HDR_OCTETS = 4;
  localparam int DLFS_INH_OCTETS = 3;
  localparam int DLFS_CNT_W = 16;
  localparam logic [2:0] DLFS_BIT_LAST = 3'h7;
  localparam logic [2:0] DLFS_BIT_FIRST = 3'h0;

  // Frame header fields, sampled when a frame starts.
  typedef struct packed {
    logic cmd_resp;
    logic [DLFS_ADDR_W-1:0] src_addr;
    logic ext_bit;
    logic [DLFS_ADDR_W-1:0] dst_addr;
    logic [DLFS_OCT_W-1:0] control;
    logic [DLFS_FCS_W-1:0] fcs;
  } dlfs_hdr_t;

  // One octet of a stream with its frame position marker.
  typedef struct packed {
    logic [DLFS_OCT_W-1:0] data;
    logic last;
  } dlfs_octet_t;

  // Intranet header minimum fields.
  typedef struct packed {
    logic [DLFS_NIB_W-1:0] version;
    logic [DLFS_NIB_W-1:0] msg_type;
    logic [DLFS_OCT_W-1:0] hdr_len;
    logic [DLFS_OCT_W-1:0] tos;
  } dlfs_inh_t;

  typedef enum logic [2:0] {
    DLFS_IDLE = 3'h0,
    DLFS_TXH = 3'h1,
    DLFS_FHDR = 3'h3,
    DLFS_INH = 3'h2,
    DLFS_NET = 3'h6,
    DLFS_FCS = 3'h7,
    DLFS_CLOSE = 3'h5
  } dlfs_state_t;

endpackage
`default_nettype wire
